// >>> verilog/i2cm_top.sv
// two-wire bus master: command decoder, status and serial engine
//
// How it works
// - status bit 4 shows arbitration lost
// - status bit 3 shows data byte unacknowledged
// - status bit 2 shows address unacknowledged
// - status bit 1 is any of those errors
// - status bit 0 busy; others invalid meanwhile
// - status bit 5 idle, bit 6 bus busy; bits 31-7 reserved, read back as zero
// - command ack bit acknowledges received bytes
// - command stop bit generates a stop
// - command start bit makes start or repeat
// - run bit needed for any byte transfer
// - idle send start-run: start, send, transmit
// - idle send stop-start-run: start, send, stop
// - idle receive start-run: start, receive, nack
// - idle receive: stop variant, ack variant
// - transmit run only: send, stay transmit
// - transmit stop alone, or send then stop
// - transmit send repeat start, stop optional
// - transmit receive repeat start, enter receive
// - transmit receive with stop: repeat, stop
// - address bit 0 selects receive or send
`timescale 1ns/100ps
module i2cm_top
  import i2cm_pkg::*;
(
  // system
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial clock pin, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // serial data pin, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  // bus side registers
  logic dph_wr_q;
  logic dph_rd_q;
  logic [11:0] dph_ofs_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic [7:0] tar_q;
  logic [7:0] dat_q;

  // status
  logic busy_q;
  logic arb_q;
  logic datn_q;
  logic adrn_q;
  logic err_q;
  logic busbsy_q;

  // pin synchronisers
  logic scl_m_q;
  logic scl_s_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;

  // engine
  i2cm_eng_t eng_q;
  i2cm_mst_t mst_q;
  i2cm_mst_t op_next_q;
  logic [1:0] ph_q;
  logic [7:0] cnt_q;
  logic [3:0] bitn_q;
  logic [7:0] shift_q;
  logic op_data_q;
  logic op_rx_q;
  logic op_ack_q;
  logic op_stop_q;
  logic in_data_q;
  logic nack_q;
  logic scl_oe_q;
  logic sda_oe_q;

  // address phase decode; hsize is always a word here
  wire aph = hsel & htrans[1] & hready;
  wire [11:0] a_ofs = haddr[11:0];
  wire wr_tar = dph_wr_q & (dph_ofs_q == OFS_TAR);
  wire wr_mcs = dph_wr_q & (dph_ofs_q == OFS_MCS);
  wire wr_dat = dph_wr_q & (dph_ofs_q == OFS_DAT);

  // command fields and direction select
  wire c_run = hwdata[CMD_RUN];
  wire c_start = hwdata[CMD_START];
  wire c_stop = hwdata[CMD_STOP];
  wire c_ack = hwdata[CMD_ACK];
  wire rs = tar_q[TAR_RS];

  // decoding of the written command against the master state
  wire sr = c_start & c_run;
  wire illegal = rs & c_ack & c_stop;
  wire acc_sr = sr & ~illegal & (mst_q != MS_RX);
  wire acc_send = (mst_q == MS_TX) & ~c_start & c_run;
  wire acc_stop = (mst_q == MS_TX) & ~c_start & ~c_run & c_stop;
  wire cmd_ok = acc_sr | acc_send | acc_stop;
  wire cmd_go = wr_mcs & ~busy_q & cmd_ok;
  // after a stop the master is idle, else it follows the direction
  wire go_rx = acc_sr & rs;
  wire [1:0] nxt_bits = c_stop ? MS_IDLE : (go_rx ? MS_RX : MS_TX);
  wire i2cm_mst_t cmd_next = i2cm_mst_t'(nxt_bits);

  // status word, reserved bits read as zero
  wire idle_w = (mst_q == MS_IDLE) & ~busy_q;
  wire [6:0] sts = {busbsy_q, idle_w, arb_q, datn_q, adrn_q, err_q,
                    busy_q};
  wire [31:0] rd_mux =
    (dph_ofs_q == OFS_TAR) ? {24'h000000, tar_q} :
    (dph_ofs_q == OFS_MCS) ? {25'h0000000, sts} :
    (dph_ofs_q == OFS_DAT) ? {24'h000000, dat_q} : 32'h00000000;

  // quarter phase timing; a released clock held low stretches it
  wire stall = ~scl_oe_q & ~scl_s_q;
  wire tick = (eng_q != E_IDLE) & ~stall & (cnt_q == QTR_CYC - 8'h01);
  wire rx_byte = op_rx_q & in_data_q;
  wire ack_slot = (bitn_q == LAST_BIT);
  // value put on the data line in this bit slot; one means released
  wire bit_val = ack_slot ? (rx_byte ? ~op_ack_q : 1'b1) :
                 (rx_byte ? 1'b1 : shift_q[7]);
  // lost arbitration: we released the line and someone holds it low
  wire arb_hit = tick & (eng_q == E_BIT) & (ph_q == 2'd2) & ~ack_slot &
                 ~rx_byte & bit_val & ~sda_s_q;
  wire byte_end = tick & (eng_q == E_BIT) & (ph_q == 2'd3) & ack_slot;

  // pins: open drain, only ever pulled low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = 1'b0;

  // two flops on each pin before any logic looks at it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // bus busy from start and stop seen on the wires by anyone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busbsy_q <= 1'b0;
    end else if (scl_s_q & sda_p_q & ~sda_s_q) begin
      busbsy_q <= 1'b1;
    end else if (scl_s_q & ~sda_p_q & sda_s_q) begin
      busbsy_q <= 1'b0;
    end
  end

  // ahb data phase; reads take one wait state so they never go stale
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q <= 1'b0;
      dph_rd_q <= 1'b0;
      dph_ofs_q <= 12'h000;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else begin
      dph_wr_q <= aph & hwrite;
      dph_rd_q <= aph & ~hwrite;
      if (aph) begin
        dph_ofs_q <= a_ofs;
      end
      hready_q <= ~(aph & ~hwrite);
      if (dph_rd_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // address and data registers; a transfer in flight locks them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tar_q <= TAR_RST;
      dat_q <= DAT_RST;
    end else begin
      if (wr_tar & ~busy_q) begin
        tar_q <= hwdata[7:0];
      end
      if (wr_dat & ~busy_q) begin
        dat_q <= hwdata[7:0];
      end else if (byte_end & rx_byte) begin
        dat_q <= shift_q; // received byte for software
      end
    end
  end

  // quarter counter, restarted at every phase change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 8'h00;
    end else if (eng_q == E_IDLE || tick) begin
      cnt_q <= 8'h00;
    end else if (!stall) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // error flags: cleared when a command is taken, set by the engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arb_q <= 1'b0;
      adrn_q <= 1'b0;
      datn_q <= 1'b0;
      err_q <= 1'b0;
    end else if (cmd_go) begin
      arb_q <= 1'b0;
      adrn_q <= 1'b0;
      datn_q <= 1'b0;
      err_q <= 1'b0;
    end else if (arb_hit) begin
      arb_q <= 1'b1;
      err_q <= 1'b1;
    end else if (byte_end & nack_q & ~rx_byte) begin
      adrn_q <= ~in_data_q;
      datn_q <= in_data_q;
      err_q <= 1'b1;
    end
  end

  // serial engine: start, byte slots, stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_q <= E_IDLE;
      mst_q <= MS_IDLE;
      op_next_q <= MS_IDLE;
      busy_q <= 1'b0;
      ph_q <= 2'd0;
      bitn_q <= 4'h0;
      shift_q <= 8'h00;
      op_data_q <= 1'b0;
      op_rx_q <= 1'b0;
      op_ack_q <= 1'b0;
      op_stop_q <= 1'b0;
      in_data_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (eng_q == E_IDLE) begin
      if (cmd_go) begin
        busy_q <= 1'b1;
        ph_q <= 2'd0;
        bitn_q <= 4'h0;
        op_data_q <= c_run;
        op_rx_q <= go_rx;
        op_ack_q <= c_ack;
        op_stop_q <= c_stop;
        op_next_q <= cmd_next;
        in_data_q <= ~acc_sr;
        // address byte carries the direction in its lowest bit
        shift_q <= acc_sr ? tar_q : dat_q;
        if (acc_sr) begin
          eng_q <= E_START;
        end else if (c_run) begin
          eng_q <= E_BIT;
        end else begin
          eng_q <= E_STOP;
        end
      end
    end else if (arb_hit) begin
      // give the bus up at once, no stop of our own
      eng_q <= E_IDLE;
      mst_q <= MS_IDLE;
      busy_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (tick) begin
      ph_q <= ph_q + 2'd1;
      unique case (eng_q)
        E_START: begin
          // release data, release clock, data low, clock low
          unique case (ph_q)
            2'd0: sda_oe_q <= 1'b0;
            2'd1: scl_oe_q <= 1'b0;
            2'd2: sda_oe_q <= 1'b1;
            2'd3: begin
              scl_oe_q <= 1'b1;
              eng_q <= E_BIT;
            end
          endcase
        end
        E_BIT: begin
          unique case (ph_q)
            2'd0: sda_oe_q <= ~bit_val;
            2'd1: scl_oe_q <= 1'b0;
            2'd2: begin
              if (ack_slot) begin
                nack_q <= sda_s_q;
              end else begin
                shift_q <= {shift_q[6:0], sda_s_q};
              end
            end
            2'd3: begin
              scl_oe_q <= 1'b1;
              bitn_q <= bitn_q + 4'h1;
              if (ack_slot) begin
                bitn_q <= 4'h0;
                if (nack_q & ~rx_byte) begin
                  eng_q <= E_STOP;
                  op_next_q <= MS_IDLE;
                end else if (!in_data_q && op_data_q) begin
                  in_data_q <= 1'b1;
                  shift_q <= dat_q;
                end else if (op_stop_q) begin
                  eng_q <= E_STOP;
                end else begin
                  eng_q <= E_IDLE;
                  mst_q <= op_next_q;
                  busy_q <= 1'b0;
                  sda_oe_q <= 1'b0;
                end
              end
            end
          endcase
        end
        E_STOP: begin
          // data low, release clock, release data while clock high
          unique case (ph_q)
            2'd0: sda_oe_q <= 1'b1;
            2'd1: scl_oe_q <= 1'b0;
            2'd2: sda_oe_q <= 1'b0;
            2'd3: begin
              eng_q <= E_IDLE;
              mst_q <= MS_IDLE;
              busy_q <= 1'b0;
            end
          endcase
        end
        default: eng_q <= E_IDLE;
      endcase
    end
  end

endmodule // i2cm_top

// >>> verilog/i2cm_pkg.sv
// shared constants and types of the two-wire master command block
package i2cm_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_TAR = 12'h000;
  localparam logic [11:0] OFS_MCS = 12'h004;
  localparam logic [11:0] OFS_DAT = 12'h008;

  // command field positions of master_control_status on write
  localparam int CMD_RUN = 0;
  localparam int CMD_START = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_ACK = 3;

  // status field positions of master_control_status on read
  localparam int STS_BUSY = 0;
  localparam int STS_ERROR = 1;
  localparam int STS_ADRN = 2;
  localparam int STS_DATN = 3;
  localparam int STS_ARB = 4;
  localparam int STS_IDLE = 5;
  localparam int STS_BUSBSY = 6;

  // receive/send select in target_address_register
  localparam int TAR_RS = 0;

  // reset values
  localparam logic [7:0] TAR_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;

  // timing: one serial clock period is four quarter phases
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC_INT =
    (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] QTR_CYC = 8'(QTR_CYC_INT);

  // index of the last bit in one byte slot, the acknowledge bit
  localparam logic [3:0] LAST_BIT = 4'h8;

  // serial engine, gray coded along idle-start-bit-stop
  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_START = 2'b01,
    E_BIT = 2'b11,
    E_STOP = 2'b10
  } i2cm_eng_t;

  // master protocol state seen by the command decoder
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_TX = 2'b01,
    MS_RX = 2'b11
  } i2cm_mst_t;
endpackage

// >>> tb/i2cm_properties.sv
// port checks of the two-wire master command block
`timescale 1ns/100ps
module i2cm_properties
  import i2cm_pkg::*;
(
  // system
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // serial pins
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_q, wr_q;
  logic [11:0] adr_q;
  logic [3:0] cmd_q;
  wire take = hsel & htrans[1] & hready;
  wire mcs_rd = rd_q & hreadyout & (adr_q == OFS_MCS);
  // follow the data phase; last command kept so a start can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 12'h000;
      cmd_q <= 4'h0;
    end else begin
      rd_q <= take ? !hwrite : rd_q & !hreadyout;
      wr_q <= take & hwrite;
      adr_q <= take ? haddr[11:0] : adr_q;
      cmd_q <= (wr_q && adr_q == OFS_MCS) ? hwdata[3:0] : cmd_q;
    end
  end
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (take && !hwrite |=> s_rd_wait)
    else $error("read wait wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_rsvd_zero: assert property (mcs_rd |-> hrdata[31:7] == 25'h0)
    else $error("reserved bits set");
  a_error_sum: assert property (mcs_rd && !hrdata[STS_BUSY] |->
    hrdata[STS_ERROR] == |hrdata[STS_ARB:STS_ADRN])
    else $error("error bit wrong");
  a_busy_idle: assert property (mcs_rd && hrdata[STS_BUSY] |->
    !hrdata[STS_IDLE]) else $error("busy and idle");
  a_quiet_idle: assert property (mcs_rd && !hrdata[STS_BUSY] |=>
    $stable(scl_oe) && $stable(sda_oe)) else $error("lines move idle");
  a_start_cmd: assert property ($rose(sda_oe) && scl_i && !scl_oe
    |-> cmd_q[CMD_START] && cmd_q[CMD_RUN]) else $error("stray start");
  a_scl_low: assert property ($rose(scl_oe) |-> scl_oe[*8])
    else $error("clock low too short");
endmodule // i2cm_properties

bind i2cm_top i2cm_properties u_prop (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .scl_i,
  .scl_oe, .sda_oe);

// >>> tb/i2cm_slave.sv
// behavioural slave device on the two-wire bus
`timescale 1ns/100ps
module i2cm_slave #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // bus wires, pulled up outside
  input wire logic scl,
  input wire logic sda,
  // bench controls
  input wire logic nack_data,
  input wire logic [7:0] tx_byte,
  // drive and observations
  output logic sda_oe,
  output logic [7:0] rx_byte,
  output logic mst_ack
);
  logic act = 1'b0, first = 1'b0, rd = 1'b0;
  logic [3:0] bitc = 4'h0;
  logic [7:0] sh = 8'h00;
  initial {sda_oe, rx_byte, mst_ack} = 10'h000;
  // start or repeated start: an address byte follows
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      first = 1'b1;
      bitc = 4'h0;
    end
  end
  // stop ends the transfer
  always @(posedge sda) if (scl) act = 1'b0;
  // sample while the clock is high
  always @(posedge scl) begin
    if (act && bitc < 4'h8) sh = {sh[6:0], sda};
    if (act && bitc == 4'h8 && rd && !first) mst_ack = !sda;
    if (act) bitc = bitc + 4'h1;
  end
  // data line changes only while the clock is low
  always @(negedge scl) begin
    if (act && bitc == 4'h8 && first) begin
      rd = sh[0];
      act = sh[7:1] == ADDR;
      sda_oe = act;
    end else if (act && bitc == 4'h8) begin
      rx_byte = rd ? rx_byte : sh;
      sda_oe = !rd && !nack_data;
    end else if (act && bitc == 4'h9) begin
      rd = rd && (first || mst_ack);
      first = 1'b0;
      bitc = 4'h0;
      sda_oe = rd && !tx_byte[7];
    end else if (act) begin
      sda_oe = rd && !first && !tx_byte[4'h7 - bitc];
    end
  end
endmodule // i2cm_slave

// >>> tb/i2cm_top_bench.sv
// self-checking bench for the two-wire master command block
`timescale 1ns/100ps
module i2cm_top_bench
  import i2cm_pkg::*;
;
  logic hclk, hresetn = 1'b0, hwrite = 1'b0, nack_data = 1'b0;
  logic hreadyout, scl_oe, sda_oe, s_oe, mst_ack, hresp, scl_o, sda_o;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0] rx_byte;
  int errors = 0, n_tests = 0;
  // open-drain wires with pull-ups
  wire scl = !scl_oe;
  wire sda = !(sda_oe || s_oe);
  i2cm_top DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
    .sda_oe);
  i2cm_slave u_slv (.scl, .sda, .nack_data, .tx_byte(8'ha5),
    .sda_oe(s_oe), .rx_byte, .mst_ack);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = !hclk;
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one word; each phase held until hready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // command, busy read at once, then poll to the final status
  task automatic cmd(input logic [3:0] c, input logic b,
      input logic [31:0] exp);
    int n;
    xfer(1'b1, OFS_MCS, {28'h0, c});
    xfer(1'b0, OFS_MCS, 32'h0);
    check({31'h0, rd[STS_BUSY]}, {31'h0, b});
    n = 0;
    while (rd[STS_BUSY] !== 1'b0 && n < 9000) begin
      xfer(1'b0, OFS_MCS, 32'h0);
      n++;
    end
    check(rd, exp);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, 12'h010, 32'hffffffff);
    xfer(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, OFS_MCS, 32'h0);
    check(rd, 32'h20);
    check({29'h0, hresp, scl_o, sda_o}, 32'h0);
    $display("reset values done");
    xfer(1'b1, OFS_TAR, 32'h54);
    xfer(1'b1, OFS_DAT, 32'h3c);
    cmd(4'h7, 1'b1, 32'h20);
    check({24'h0, rx_byte}, 32'h3c);
    $display("send and stop done");
    xfer(1'b1, OFS_TAR, 32'h56);
    cmd(4'h7, 1'b1, 32'h26);
    $display("address nack done");
    xfer(1'b1, OFS_TAR, 32'h54);
    cmd(4'hb, 1'b1, 32'h40);
    xfer(1'b1, OFS_DAT, 32'h81);
    cmd(4'h1, 1'b1, 32'h40);
    check({24'h0, rx_byte}, 32'h81);
    xfer(1'b1, OFS_DAT, 32'h5a);
    cmd(4'h3, 1'b1, 32'h40);
    check({24'h0, rx_byte}, 32'h5a);
    cmd(4'h4, 1'b1, 32'h20);
    cmd(4'h4, 1'b0, 32'h20);
    $display("transmit steps done");
    nack_data <= 1'b1;
    cmd(4'h7, 1'b1, 32'h2a);
    nack_data <= 1'b0;
    $display("data nack done");
    xfer(1'b1, OFS_TAR, 32'h55);
    cmd(4'h7, 1'b1, 32'h20);
    xfer(1'b0, OFS_DAT, 32'h0);
    check(rd, 32'ha5);
    check({31'h0, mst_ack}, 32'h0);
    cmd(4'hb, 1'b1, 32'h40);
    check({31'h0, mst_ack}, 32'h1);
    $display("receive done");
    // a reset in mid-run is the only way out of the receive state
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, OFS_MCS, 32'h0);
    check(rd, 32'h20);
    xfer(1'b1, OFS_TAR, 32'h55);
    cmd(4'h3, 1'b1, 32'h40);
    check({31'h0, mst_ack}, 32'h0);
    xfer(1'b0, OFS_DAT, 32'h0);
    check(rd, 32'ha5);
    $display("reset and receive nack done");
    end_sim;
  end
  // the run needs about 80k cycles; give up at 95k
  initial begin
    #1900000;
    errors++;
    end_sim;
  end
endmodule // i2cm_top_bench
